// ===== design/tcit_channel.sv
// one timer channel: control word, count load, counting and output
`timescale 1ns/1ps
module tcit_channel
   import tcit_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control from the port decoder
   input wire logic mode_wr,
   input wire logic [7:0] mode_data,
   input wire logic count_wr,
   input wire logic [7:0] count_data,
   input wire logic count_rd,
   input wire logic latch_count,
   input wire logic latch_status,
   input wire logic gate,
   // results
   output logic [7:0] read_data,
   output logic out
);
   typedef struct packed {
      logic [1:0] access;
      logic [2:0] mode;
      logic bcd;
      logic [15:0] initial_count;
      logic [15:0] counter;
      logic null_count;
      logic load_pending;
      logic armed;
      logic counting;
      logic out;
      logic write_msb;
      logic read_msb;
      logic [15:0] latched;
      logic [1:0] latched_left;
      logic [7:0] status;
      logic status_valid;
      logic gate_q;
      logic [7:0] read_data;
   } tcit_chan_s;

   tcit_chan_s r;
   tcit_chan_s n;
   logic [15:0] dec_result;
   logic [1:0] dec_step;
   logic [2:0] eff_mode;
   logic gate_rise;

   tcit_decrement u_dec (
      .value(r.counter),
      .step(dec_step),
      .bcd(r.bcd),
      .result(dec_result)
   );

   always_comb begin
      eff_mode = (r.mode[1]) ? {1'b0, r.mode[1:0]} : r.mode;
      gate_rise = gate && !r.gate_q;
      dec_step = 2'h0;
      if (r.counting && gate && eff_mode != tcit_mode1 &&
          eff_mode != tcit_mode5) begin
         dec_step = (eff_mode == tcit_mode3) ? 2'h2 : 2'h1;
      end else if (r.counting &&
                   (eff_mode == tcit_mode1 || eff_mode == tcit_mode5)) begin
         dec_step = 2'h1;
      end
   end

   always_comb begin
      n = r;
      n.gate_q = gate;
      if (mode_wr) begin
         n.access = mode_data[tcit_acc_hi:tcit_acc_lo];
         n.mode = mode_data[tcit_mode_hi:tcit_mode_lo];
         n.bcd = mode_data[tcit_bcd_bit];
         n.counter = 16'h0000;
         n.initial_count = 16'h0000;
         n.counting = 1'b0;
         n.armed = 1'b0;
         n.load_pending = 1'b0;
         n.null_count = 1'b1;
         n.write_msb = 1'b0;
         n.read_msb = 1'b0;
         n.latched_left = 2'h0;
         n.status_valid = 1'b0;
         n.out = (mode_data[tcit_mode_hi:tcit_mode_lo] != tcit_mode0);
      end else begin
         if (count_wr) begin
            case (r.access)
               tcit_acc_low: begin
                  n.initial_count = {8'h00, count_data};
                  n.load_pending = 1'b1;
               end
               tcit_acc_high: begin
                  n.initial_count = {count_data, 8'h00};
                  n.load_pending = 1'b1;
               end
               tcit_acc_both: begin
                  if (!r.write_msb) begin
                     n.initial_count[7:0] = count_data;
                  end else begin
                     n.initial_count[15:8] = count_data;
                     n.load_pending = 1'b1;
                  end
                  n.write_msb = !r.write_msb;
               end
               default: begin
               end
            endcase
            n.null_count = 1'b1;
            if (eff_mode == tcit_mode0) begin
               n.out = 1'b0;
            end
         end
         // counting
         if (dec_step != 2'h0) begin
            n.counter = dec_result;
            case (eff_mode)
               tcit_mode0: begin
                  if (dec_result == 16'h0000) begin
                     n.out = 1'b1;
                     n.counting = 1'b0;
                  end
               end
               tcit_mode1: begin
                  if (dec_result == 16'h0000) begin
                     n.out = 1'b1;
                     n.counting = 1'b0;
                  end
               end
               tcit_mode2: begin
                  n.out = (dec_result != 16'h0001);
                  if (r.counter == 16'h0001) begin
                     n.counter = r.initial_count;
                  end
               end
               tcit_mode3: begin
                  if (r.counter == 16'h0002 || r.counter == 16'h0001) begin
                     n.out = !r.out;
                     n.counter = r.initial_count;
                  end
               end
               default: begin
                  if (dec_result == 16'h0000) begin
                     n.out = 1'b0;
                     n.counting = 1'b0;
                  end
               end
            endcase
         end else if ((eff_mode == tcit_mode4 || eff_mode == tcit_mode5) &&
                      !r.out) begin
            n.out = 1'b1;
         end
         // transfer of the written count into the counting element; in modes 1 and 5 this only arms for the gate edge
         if (r.load_pending && !count_wr) begin
            n.load_pending = 1'b0;
            n.null_count = 1'b0;
            if (eff_mode == tcit_mode1 || eff_mode == tcit_mode5) begin
               n.armed = 1'b1;
            end else begin
               n.counter = r.initial_count;
               n.counting = 1'b1;
               if (eff_mode == tcit_mode2 || eff_mode == tcit_mode3 ||
                   eff_mode == tcit_mode4) begin
                  n.out = 1'b1;
               end
            end
         end
         if (gate_rise && (r.armed || r.counting) &&
             (eff_mode == tcit_mode1 || eff_mode == tcit_mode5)) begin
            n.counter = r.initial_count;
            // null flag is left alone here: a count write in this cycle wins
            n.counting = 1'b1;
            if (eff_mode == tcit_mode1) begin
               n.out = 1'b0;
            end
         end
         // read side
         if (count_rd) begin
            if (r.status_valid) begin
               n.status_valid = 1'b0;
            end else if (r.latched_left != 2'h0) begin
               n.latched_left = r.latched_left - 2'h1;
               n.latched = {8'h00, r.latched[15:8]};
            end else if (r.access == tcit_acc_both) begin
               n.read_msb = !r.read_msb;
            end
         end
         if (latch_status && !r.status_valid) begin
            n.status = {r.out, r.null_count, r.access, r.mode, r.bcd};
            n.status_valid = 1'b1;
         end
         if (latch_count && r.latched_left == 2'h0) begin
            case (r.access)
               tcit_acc_high: n.latched = {8'h00, r.counter[15:8]};
               default: n.latched = r.counter;
            endcase
            n.latched_left = (r.access == tcit_acc_both) ? 2'h2 : 2'h1;
         end
      end
      // data returned to the host, registered
      if (n.status_valid) begin
         n.read_data = n.status;
      end else if (n.latched_left != 2'h0) begin
         n.read_data = n.latched[7:0];
      end else if (n.access == tcit_acc_high ||
                   (n.access == tcit_acc_both && n.read_msb)) begin
         n.read_data = n.counter[15:8];
      end else begin
         n.read_data = n.counter[7:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign read_data = r.read_data;
   assign out = r.out;

   a_mode_null: assert property (
      @(posedge clock) disable iff (!rst_n)
      mode_wr |=> r.null_count) else $error("null flag not set");
   a_load_clear: assert property (
      @(posedge clock) disable iff (!rst_n)
      (r.load_pending && !count_wr && !mode_wr) |=> !r.null_count)
      else $error("null flag not cleared");
   a_write_null: assert property (
      @(posedge clock) disable iff (!rst_n)
      (count_wr && !mode_wr) |=> r.null_count)
      else $error("null flag not set by count write");
   a_mode0_low: assert property (
      @(posedge clock) disable iff (!rst_n)
      (count_wr && !mode_wr && eff_mode == tcit_mode0 && dec_step == 2'h0)
      |=> !out) else $error("mode 0 output not low");
   a_mode_out: assert property (
      @(posedge clock) disable iff (!rst_n)
      mode_wr |=> out == ($past(mode_data[tcit_mode_hi:tcit_mode_lo]) !=
      tcit_mode0)) else $error("output not reset by mode write");
   a_mode2_pulse: assert property (
      @(posedge clock) disable iff (!rst_n)
      (eff_mode == tcit_mode2 && !out && gate && r.counting && !mode_wr)
      |=> out) else $error("mode 2 low pulse too long");
   a_single_byte: assert property (
      @(posedge clock) disable iff (!rst_n)
      (count_wr && !mode_wr && r.access == tcit_acc_low)
      |=> r.initial_count[15:8] == 8'h00)
      else $error("other byte not cleared");
   a_mode4_strobe: assert property (
      @(posedge clock) disable iff (!rst_n)
      (eff_mode == tcit_mode4 && !out && !mode_wr && !count_wr) |=> out)
      else $error("mode 4 strobe longer than one clock");
   a_latch_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      (r.latched_left != 2'h0 && !count_rd && !mode_wr)
      |=> $stable(r.latched)) else $error("latch overwritten");
   a_status_first: assert property (
      @(posedge clock) disable iff (!rst_n)
      (r.status_valid && !mode_wr) |-> read_data == r.status)
      else $error("status not returned first");
endmodule

// ===== design/tcit_pkg.sv
// package: register map, field layout and encodings of the interval timer
package tcit_pkg;
   localparam logic [7:0] tcit_ch0_count_port = 8'h40;
   localparam logic [7:0] tcit_ch1_count_port = 8'h41;
   localparam logic [7:0] tcit_ch2_count_port = 8'h42;
   localparam logic [7:0] tcit_mode_command = 8'h43;
   localparam logic [7:0] tcit_sys_control_port = 8'h61;
   localparam int tcit_sel_hi = 7;
   localparam int tcit_sel_lo = 6;
   localparam int tcit_acc_hi = 5;
   localparam int tcit_acc_lo = 4;
   localparam int tcit_mode_hi = 3;
   localparam int tcit_mode_lo = 1;
   localparam int tcit_bcd_bit = 0;
   localparam int tcit_rb_latch_count_n = 5;
   localparam int tcit_rb_latch_status_n = 4;
   localparam int tcit_rb_sel_ch0 = 1;
   localparam int tcit_ch2_gate_bit = 0;
   localparam int tcit_ch2_out_bit = 5;
   localparam logic [1:0] tcit_sel_readback = 2'h3;
   localparam logic [1:0] tcit_acc_latch = 2'h0;
   localparam logic [1:0] tcit_acc_low = 2'h1;
   localparam logic [1:0] tcit_acc_high = 2'h2;
   localparam logic [1:0] tcit_acc_both = 2'h3;
   localparam logic [2:0] tcit_mode0 = 3'h0;
   localparam logic [2:0] tcit_mode1 = 3'h1;
   localparam logic [2:0] tcit_mode2 = 3'h2;
   localparam logic [2:0] tcit_mode3 = 3'h3;
   localparam logic [2:0] tcit_mode4 = 3'h4;
   localparam logic [2:0] tcit_mode5 = 3'h5;
   localparam logic [7:0] tcit_status_reset = 8'h00;
   localparam logic [7:0] tcit_mode_reset = 8'h00;
endpackage

// ===== design/tcit_decrement.sv
// decrementer: one or two steps down in binary or four-digit bcd, zero wraps to max
`timescale 1ns/1ps
module tcit_decrement
   import tcit_pkg::*;
(
   // operand
   input wire logic [15:0] value,
   input wire logic [1:0] step,
   input wire logic bcd,
   // result
   output logic [15:0] result
);
   logic [15:0] once;
   logic [15:0] twice;

   function automatic logic [15:0] dec1(input logic [15:0] v,
                                        input logic b);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!b) begin
         r = v - 16'h0001;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (borrow) begin
               if (v[i*4 +: 4] == 4'h0) begin
                  r[i*4 +: 4] = 4'h9;
               end else begin
                  r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   always_comb begin
      once = dec1(value, bcd);
      twice = dec1(once, bcd);
      result = (step == 2'h2) ? twice : ((step == 2'h1) ? once : value);
   end
endmodule

// ===== design/tcit_timer.sv
// three-channel interval timer with byte-wide port decoder
`timescale 1ns/1ps
module tcit_timer
   import tcit_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // host i/o port access
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // timer outputs
   output logic [2:0] timer_out
);
   typedef struct packed {
      logic ch2_gate_control;
      logic [7:0] rdata;
   } tcit_top_s;

   tcit_top_s r;
   tcit_top_s n;
   logic [2:0] gate;
   logic [2:0] mode_wr;
   logic [2:0] count_wr;
   logic [2:0] count_rd;
   logic [2:0] latch_count;
   logic [2:0] latch_status;
   logic [7:0] ch_rdata [3];
   logic cmd_wr;
   logic readback;
   logic [1:0] sel;

   always_comb begin
      cmd_wr = io_wr && io_addr == tcit_mode_command;
      sel = io_wdata[tcit_sel_hi:tcit_sel_lo];
      readback = cmd_wr && sel == tcit_sel_readback;
      gate = {r.ch2_gate_control, 1'b1, 1'b1};
   end

   generate
      for (genvar c = 0; c < 3; c++) begin : g_chan
         always_comb begin
            mode_wr[c] = cmd_wr && !readback && sel == 2'(c) &&
               io_wdata[tcit_acc_hi:tcit_acc_lo] != tcit_acc_latch;
            latch_count[c] = (cmd_wr && !readback && sel == 2'(c) &&
               io_wdata[tcit_acc_hi:tcit_acc_lo] == tcit_acc_latch) ||
               (readback && io_wdata[tcit_rb_sel_ch0 + c] &&
               !io_wdata[tcit_rb_latch_count_n]);
            latch_status[c] = readback && io_wdata[tcit_rb_sel_ch0 + c] &&
               !io_wdata[tcit_rb_latch_status_n];
            count_wr[c] = io_wr && io_addr == tcit_ch0_count_port + 8'(c);
            count_rd[c] = io_rd && io_addr == tcit_ch0_count_port + 8'(c);
         end
         tcit_channel u_chan (
            .clock(clock),
            .rst_n(rst_n),
            .mode_wr(mode_wr[c]),
            .mode_data(io_wdata),
            .count_wr(count_wr[c]),
            .count_data(io_wdata),
            .count_rd(count_rd[c]),
            .latch_count(latch_count[c]),
            .latch_status(latch_status[c]),
            .gate(gate[c]),
            .read_data(ch_rdata[c]),
            .out(timer_out[c])
         );
      end
   endgenerate

   always_comb begin
      n = r;
      if (io_wr && io_addr == tcit_sys_control_port) begin
         n.ch2_gate_control = io_wdata[tcit_ch2_gate_bit];
      end
      case (io_addr)
         tcit_ch0_count_port: n.rdata = ch_rdata[0];
         tcit_ch1_count_port: n.rdata = ch_rdata[1];
         tcit_ch2_count_port: n.rdata = ch_rdata[2];
         tcit_sys_control_port: begin
            n.rdata = 8'h00;
            n.rdata[tcit_ch2_out_bit] = timer_out[2];
            n.rdata[tcit_ch2_gate_bit] = r.ch2_gate_control;
         end
         default: n.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign io_rdata = r.rdata;

   a_readback_prio: assert property (
      @(posedge clock) disable iff (!rst_n)
      readback |-> mode_wr == 3'h0 && ((latch_count | latch_status) &
      ~io_wdata[tcit_rb_sel_ch0 + 2:tcit_rb_sel_ch0]) == 3'h0)
      else $error("read-back touched an unselected channel");
   a_gate_follow: assert property (
      @(posedge clock) disable iff (!rst_n)
      (io_wr && io_addr == tcit_sys_control_port)
      |=> gate[2] == $past(io_wdata[tcit_ch2_gate_bit]))
      else $error("gate not updated");
endmodule

// ===== test/tcit_host_model.sv
// host processor model: byte-wide i/o writes and reads
`timescale 1ns/1ps
module tcit_host_model
   import tcit_pkg::*;
(
   // clock
   input wire logic clock,
   // i/o port
   output logic [7:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   initial begin
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end

   // one-cycle write strobe; data inverted once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clock);
      io_wr <= 1'b0;
      io_wdata <= ~d;
   endtask

   // read data is registered, so it is taken just after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      #1 d = io_rdata;
   endtask
endmodule

// ===== test/tcit_timer_test.sv
// self-checking bench of the three-channel interval timer
`timescale 1ns/1ps
module tcit_timer_test;
   import tcit_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] io_addr;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic io_wr;
   logic io_rd;
   logic [2:0] timer_out;
   int failures = 0;
   int checks_done = 0;
   int n;
   int w;
   int k;
   logic [31:0] seed = 32'he318e418;
   logic [7:0] lo;
   logic [7:0] hi;
   logic [7:0] ctl [4];
   logic [15:0] cv [4];
   logic [15:0] per [4];

   always #5 clock = ~clock;

   tcit_timer i_dut (.clock(clock), .rst_n(rst_n), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .timer_out(timer_out));
   tcit_host_model i_host (.clock(clock), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // cycles until a channel output shows a level, capped at lim
   task automatic wait_lvl(input int ch, input logic lv, input int lim,
      output int c);
      c = 0;
      while (timer_out[ch] !== lv && c < lim) begin
         @(posedge clock);
         #1;
         c++;
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clock);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      chk("out after reset", 16'(timer_out), 16'h0000);
      // status only after a read-back asking for it
      i_host.wr(tcit_mode_command, 8'he2);
      i_host.rd(tcit_ch0_count_port, lo);
      chk("reset status", 16'(lo), 16'(tcit_status_reset));
      i_host.rd(8'h50, lo);
      chk("unmapped read", 16'(lo), 16'h0000);
      // null flag stays set until the second byte is in
      i_host.wr(tcit_mode_command, 8'h34);
      i_host.wr(tcit_ch0_count_port, 8'h09);
      i_host.wr(tcit_mode_command, 8'he2);
      i_host.rd(tcit_ch0_count_port, lo);
      chk("null set", 16'(lo & 8'h7f), 16'h0074);
      i_host.wr(tcit_ch0_count_port, 8'h00);
      i_host.wr(tcit_mode_command, 8'he2);
      i_host.rd(tcit_ch0_count_port, lo);
      chk("null clear", 16'(lo & 8'h7f), 16'h0034);
      // rate generator: random, bcd, bcd zero and alias code
      k = 3 + int'(xs() % 18);
      ctl = '{8'h34, 8'h35, 8'h35, 8'h3c};
      cv = '{16'(k), 16'h0010, 16'h0000, 16'h0007};
      per = '{16'(k), 16'd10, 16'd10000, 16'd7};
      for (int i = 0; i < 4; i++) begin
         i_host.wr(tcit_mode_command, ctl[i]);
         i_host.wr(tcit_ch0_count_port, cv[i][7:0]);
         i_host.wr(tcit_ch0_count_port, cv[i][15:8]);
         wait_lvl(0, 1'b0, 20000, n);
         wait_lvl(0, 1'b1, 5, w);
         chk("m2 low width", 16'(w), 16'd1);
         wait_lvl(0, 1'b0, 20000, n);
         chk("m2 period", 16'(w + n), per[i]);
      end
      // read-back: status first, then both latched bytes
      i_host.wr(tcit_mode_command, 8'hc2);
      i_host.rd(tcit_ch0_count_port, lo);
      chk("rb status", 16'(lo & 8'h71), 16'h0030);
      i_host.rd(tcit_ch0_count_port, lo);
      i_host.rd(tcit_ch0_count_port, hi);
      chk("rb count", 16'({hi, lo} >= 1 && {hi, lo} <= 7), 16'd1);
      // latch command keeps counting and the mode untouched
      i_host.wr(tcit_mode_command, 8'h00);
      i_host.wr(tcit_mode_command, 8'h00);
      i_host.rd(tcit_ch0_count_port, lo);
      i_host.rd(tcit_ch0_count_port, hi);
      chk("latch count", 16'({hi, lo} >= 1 && {hi, lo} <= 7), 16'd1);
      wait_lvl(0, 1'b0, 50, n);
      wait_lvl(0, 1'b1, 5, w);
      wait_lvl(0, 1'b0, 50, n);
      chk("period after latch", 16'(w + n), 16'd7);
      // terminal count, high byte only so low byte loads as zero
      i_host.wr(tcit_mode_command, 8'h60);
      @(posedge clock);
      #1;
      chk("m0 low on mode", 16'(timer_out[1]), 16'd0);
      i_host.wr(tcit_ch1_count_port, 8'h01);
      wait_lvl(1, 1'b1, 400, n);
      chk("m0 terminal", 16'(n >= 254 && n <= 259), 16'd1);
      repeat (20) @(posedge clock);
      chk("m0 stays high", 16'(timer_out[1]), 16'd1);
      // square wave on channel 2 with gate set
      k = 2 * (2 + int'(xs() % 8));
      i_host.wr(tcit_sys_control_port, 8'h01);
      i_host.wr(tcit_mode_command, 8'hb6);
      i_host.wr(tcit_ch2_count_port, 8'(k));
      i_host.wr(tcit_ch2_count_port, 8'h00);
      wait_lvl(2, 1'b0, 100, n);
      wait_lvl(2, 1'b1, 100, n);
      chk("m3 low half", 16'(n), 16'(k / 2));
      wait_lvl(2, 1'b0, 100, n);
      chk("m3 high half", 16'(n), 16'(k / 2));
      // gate-triggered strobe: nothing until a rising gate edge
      k = 4 + int'(xs() % 10);
      i_host.wr(tcit_sys_control_port, 8'h00);
      i_host.wr(tcit_mode_command, 8'h9a);
      i_host.wr(tcit_ch2_count_port, 8'(k));
      wait_lvl(2, 1'b0, 3 * k, n);
      chk("m5 no trigger", 16'(n), 16'(3 * k));
      i_host.wr(tcit_sys_control_port, 8'h01);
      wait_lvl(2, 1'b0, 3 * k, n);
      chk("m5 strobe time", 16'(n >= k - 1 && n <= k + 3), 16'd1);
      wait_lvl(2, 1'b1, 5, n);
      chk("m5 strobe width", 16'(n), 16'd1);
      // software strobe on channel 0, low byte only
      i_host.wr(tcit_mode_command, 8'h18);
      i_host.wr(tcit_ch0_count_port, 8'(k));
      wait_lvl(0, 1'b0, 3 * k, n);
      chk("m4 strobe time", 16'(n >= k && n <= k + 2), 16'd1);
      wait_lvl(0, 1'b1, 5, n);
      chk("m4 strobe width", 16'(n), 16'd1);
      // gate-started one-shot on channel 2
      i_host.wr(tcit_sys_control_port, 8'h00);
      i_host.wr(tcit_mode_command, 8'h92);
      i_host.wr(tcit_ch2_count_port, 8'(k));
      chk("m1 high on load", 16'(timer_out[2]), 16'd1);
      i_host.wr(tcit_sys_control_port, 8'h01);
      wait_lvl(2, 1'b0, 5, n);
      wait_lvl(2, 1'b1, 3 * k, n);
      chk("m1 low time", 16'(n >= k - 1 && n <= k + 1), 16'd1);
      // system control port shows gate and channel 2 output
      i_host.rd(tcit_sys_control_port, lo);
      chk("sysctl read", 16'(lo), 16'h0021);
      tally_and_finish();
   end
endmodule
